// ---- core/i2cm_cfg.svh ----
`ifndef I2CM_CFG_SVH
`define I2CM_CFG_SVH
// register byte offsets
`define I2CM_OFS_TX      8'h00
`define I2CM_OFS_RX      8'h04
`define I2CM_OFS_CTL     8'h08
`define I2CM_OFS_BST     8'h0c
`define I2CM_OFS_ERR     8'h10
`define I2CM_OFS_INT     8'h14
`define I2CM_OFS_SDIV    8'h18
`define I2CM_OFS_CDIV    8'h1c
`define I2CM_OFS_PIO     8'h20
`define I2CM_OFS_DMOD    8'h24
`define I2CM_OFS_DCL     8'h28
`define I2CM_OFS_DCH     8'h2c
`define I2CM_OFS_DST     8'h30
// command_control fields
`define I2CM_CTL_SR      5
`define I2CM_CTL_CLOCK_STRETCH_ENABLE    4
`define I2CM_CTL_RECEIVE_ACK_SETTING    3
// command codes
`define I2CM_CMD_CLR0    3'h0
`define I2CM_CMD_START   3'h1
`define I2CM_CMD_STOP    3'h2
`define I2CM_CMD_RECV    3'h3
`define I2CM_CMD_XMIT    3'h4
`define I2CM_CMD_BAD5    3'h5
`define I2CM_CMD_BAD6    3'h6
`define I2CM_CMD_CLR7    3'h7
// bus_status fields
`define I2CM_BST_RUN     7
`define I2CM_BST_SDA     5
`define I2CM_BST_SCL     4
`define I2CM_BST_USING   3
`define I2CM_BST_BUSY    2
`define I2CM_BST_ERROR   1
`define I2CM_BST_FINISH  0
// error_status fields
`define I2CM_ERR_ACK     4
`define I2CM_ERR_SCLMM   3
`define I2CM_ERR_SDAMM   2
`define I2CM_ERR_STOP    1
`define I2CM_ERR_START   0
// interrupt_control_status fields
`define I2CM_INT_EFLAG   3
`define I2CM_INT_CFLAG   2
`define I2CM_INT_EEN     1
`define I2CM_INT_CEN     0
// pin_io_control fields
`define I2CM_PIO_HDSDA   5
`define I2CM_PIO_HDSCL   1
// dma_state fields and reset
`define I2CM_DST_TXEMPTY 3
`define I2CM_DST_RXUPD   2
`define I2CM_DST_RESET   8'h08
// reset values
`define I2CM_RST_BYTE    8'h00
// sample divider timing and bit engine last bit index
`define I2CM_SAMP_ZERO   6'd2
`define I2CM_LAST_BIT    4'd8
`endif

// ---- core/i2cm_pkg.sv ----
`default_nettype none
package i2cm_pkg;
	typedef enum logic [1:0] {st_idle, st_start, st_stop, st_bit} i2cm_state_t;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} i2cm_pins_t;
endpackage : i2cm_pkg
`default_nettype wire

// ---- core/i2cm_top.sv ----
// Overview of operation
// RQ1: sole bus master, no arbitration or slave
// RQ2: holding buffers separate from shift register
// RQ3: transmit byte shifted out MSB first
// RQ4: received bits assembled MSB first, read-only
// RQ5: command field launches start/stop/receive/transmit/clear
// RQ6: command writes ignored while running
// RQ7: soft reset reinitialises starred fields
// RQ8: clock-wait bit enables honouring clock stretching
// RQ9: ack setting on receive; DMA only last
// RQ10: status shows live data and clock levels
// RQ11: status shows bus in use and busy
// RQ12: missing acknowledge sets acknowledge error
// RQ13: driven versus sampled mismatch sets errors
// RQ14: foreign stop sets unexpected-stop error
// RQ15: foreign start sets unexpected-start error
// RQ16: errors clear on resets or valid command
// RQ17: enabled error sets error interrupt flag
// RQ18: enabled completion sets completion interrupt flag
// RQ19: sample clock is clk/(4m), or /2
// RQ20: 8-bit registers, wider accesses use low byte
// RQ21: bus clock is sample clock/(2^n*4)
// RQ22: completion clears run, sets finish, interrupts
// RQ23: line signalling follows two-wire bus timing
//
// Implementation choice: the Wishbone slave port.
`include "i2cm_cfg.svh"
`default_nettype none
module i2cm_top #(
	parameter int WB_AW = 8
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	input  wire logic          scl_i,
	input  wire logic          sda_i,
	output i2cm_pkg::i2cm_pins_t pins,
	output logic               irq_req
);

	if (WB_AW != 8)
		$error("i2cm_top: WB_AW must be 8");

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0]  transmit_byte;
	logic [7:0]  receive_byte;
	logic        clock_stretch_enable;
	logic        receive_ack_setting;
	logic        run;
	logic        using_bus;
	logic        busy;
	logic        finish;
	logic [4:0]  err;
	logic [3:0]  intcs;
	logic [3:0]  div_m;
	logic [2:0]  div_n;
	logic [7:0]  pio;
	logic [1:0]  dma_mode;
	logic [15:0] dma_cnt;
	logic        tx_empty;
	logic        rx_upd;

	// engine state
	i2cm_pkg::i2cm_state_t state;
	logic [1:0]  phase;
	logic [3:0]  bitn;
	logic [7:0]  shreg;
	logic        is_tx;
	logic        scl_low;
	logic        sda_low;
	logic        cmd_done;
	logic        rx_done;
	logic [2:0]  cur_cmd;
	logic [4:0]  err_set;
	logic        scl_q;
	logic        sda_q;

	////////////////////////////////////////////////////////////////////////
	// wishbone slave, answers one cycle after the request
	logic       req;
	logic       acc;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;

	assign req = wb_cyc_i && wb_stb_i;
	assign acc = req && wb_ack_o;
	assign wr  = acc && wb_we_i && wb_sel_i[0];  // see RQ20
	assign rd  = acc && !wb_we_i;

	always_ff @(posedge clk)
	begin
		if (!resetn)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req && !wb_ack_o;
	end

	always_comb
	begin
		rdata = 8'h00;
		if (wb_adr_i == `I2CM_OFS_TX)
			rdata = transmit_byte;
		else if (wb_adr_i == `I2CM_OFS_RX)
			rdata = receive_byte;
		else if (wb_adr_i == `I2CM_OFS_CTL)
			rdata = {3'h0, clock_stretch_enable, receive_ack_setting, cur_cmd};
		else if (wb_adr_i == `I2CM_OFS_BST)
			rdata = {run, 1'b0, sda_i, scl_i, using_bus, busy, |err,
				finish};  // see RQ10 see RQ11
		else if (wb_adr_i == `I2CM_OFS_ERR)
			rdata = {3'h0, err};
		else if (wb_adr_i == `I2CM_OFS_INT)
			rdata = {4'h0, intcs};
		else if (wb_adr_i == `I2CM_OFS_SDIV)
			rdata = {4'h0, div_m};
		else if (wb_adr_i == `I2CM_OFS_CDIV)
			rdata = {5'h00, div_n};
		else if (wb_adr_i == `I2CM_OFS_PIO)
			rdata = pio;
		else if (wb_adr_i == `I2CM_OFS_DMOD)
			rdata = {6'h00, dma_mode};
		else if (wb_adr_i == `I2CM_OFS_DCL)
			rdata = dma_cnt[7:0];
		else if (wb_adr_i == `I2CM_OFS_DCH)
			rdata = dma_cnt[15:8];
		else if (wb_adr_i == `I2CM_OFS_DST)
			rdata = {4'h0, tx_empty, rx_upd, 2'b00};
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			wb_dat_o <= 32'h0000_0000;
		else if (req && !wb_ack_o)
			wb_dat_o <= {24'h000000, rdata};  // see RQ20
	end

	////////////////////////////////////////////////////////////////////////
	// command decode
	logic       soft_rst;
	logic       cmd_wr;
	logic [2:0] code;
	logic       code_ok;
	logic       cmd_go;
	logic       err_clr;

	assign soft_rst = wr && wb_adr_i == `I2CM_OFS_CTL && wb_dat_i[`I2CM_CTL_SR];
	assign cmd_wr   = wr && wb_adr_i == `I2CM_OFS_CTL && !soft_rst;
	assign code     = wb_dat_i[2:0];
	assign code_ok  = code != `I2CM_CMD_BAD5 && code != `I2CM_CMD_BAD6;
	assign cmd_go   = cmd_wr && !run && code != `I2CM_CMD_CLR0 &&
		code != `I2CM_CMD_CLR7 && code_ok;  // see RQ5 see RQ6
	assign err_clr  = cmd_wr && !run && code_ok;  // see RQ16

	always_ff @(posedge clk)
	begin
		if (!resetn || soft_rst)
		begin
			clock_stretch_enable <= 1'b0;  // see RQ7
			receive_ack_setting  <= 1'b0;
			cur_cmd              <= 3'h0;
		end
		else if (cmd_wr && !run)
		begin
			clock_stretch_enable <= wb_dat_i[`I2CM_CTL_CLOCK_STRETCH_ENABLE];
			receive_ack_setting  <= wb_dat_i[`I2CM_CTL_RECEIVE_ACK_SETTING];
			cur_cmd              <= code;
		end
	end

	// plain configuration registers, untouched by soft reset
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			div_m    <= 4'h0;
			div_n    <= 3'h0;
			pio      <= `I2CM_RST_BYTE;
			dma_mode <= 2'h0;
		end
		else if (wr)
		begin
			if (wb_adr_i == `I2CM_OFS_SDIV)
				div_m <= wb_dat_i[3:0];
			else if (wb_adr_i == `I2CM_OFS_CDIV)
				div_n <= wb_dat_i[2:0];
			else if (wb_adr_i == `I2CM_OFS_PIO)
				pio <= wb_dat_i[7:0] & 8'h33;
			else if (wb_adr_i == `I2CM_OFS_DMOD)
				dma_mode <= wb_dat_i[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample clock and quarter-bit enables
	logic [5:0] samp_cnt;
	logic [5:0] samp_per;
	logic       samp_tick;
	logic [6:0] q_cnt;
	logic [6:0] q_lim;
	logic       qtick;

	assign samp_per  = (div_m == 4'h0) ? `I2CM_SAMP_ZERO : {div_m, 2'b00};
	assign samp_tick = samp_cnt >= samp_per - 6'd1;  // see RQ19
	assign q_lim     = (7'd1 << div_n) - 7'd1;
	assign qtick     = samp_tick && q_cnt >= q_lim;  // see RQ21

	always_ff @(posedge clk)
	begin
		if (!resetn)
			samp_cnt <= 6'd0;
		else if (samp_tick)
			samp_cnt <= 6'd0;
		else
			samp_cnt <= samp_cnt + 6'd1;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn || state == i2cm_pkg::st_idle)
			q_cnt <= 7'd0;
		else if (qtick)
			q_cnt <= 7'd0;
		else if (samp_tick)
			q_cnt <= q_cnt + 7'd1;
	end

	////////////////////////////////////////////////////////////////////////
	// bit engine: four quarters per bit, master only
	logic stall;
	logic ack_send;
	logic bit_out;
	logic drv_sda;

	assign stall    = clock_stretch_enable && phase == 2'd2 && !scl_i; // see RQ8
	assign ack_send = (dma_mode == 2'h0 || dma_cnt == 16'h0001) ?
		receive_ack_setting : 1'b0;  // see RQ9
	assign bit_out  = (bitn == `I2CM_LAST_BIT) ? (is_tx || !ack_send) :
		(!is_tx || shreg[7]);  // see RQ3
	assign drv_sda  = (bitn == `I2CM_LAST_BIT) ? !is_tx : is_tx;

	always_ff @(posedge clk)
	begin
		if (!resetn || soft_rst)
		begin
			state    <= i2cm_pkg::st_idle;
			phase    <= 2'd0;
			bitn     <= 4'd0;
			shreg    <= 8'h00;
			is_tx    <= 1'b0;
			scl_low  <= 1'b0;
			sda_low  <= 1'b0;
			cmd_done <= 1'b0;
			rx_done  <= 1'b0;
			err_set  <= 5'h00;
		end
		else
		begin
			cmd_done <= 1'b0;
			rx_done  <= 1'b0;
			err_set  <= 5'h00;
			if (state == i2cm_pkg::st_idle)
			begin
				phase <= 2'd0;
				bitn  <= 4'd0;
				if (cmd_go)
				begin
					is_tx <= code == `I2CM_CMD_XMIT;
					shreg <= transmit_byte;  // see RQ2
					case (code)
						`I2CM_CMD_START: state <= i2cm_pkg::st_start;
						`I2CM_CMD_STOP:  state <= i2cm_pkg::st_stop;
						default:         state <= i2cm_pkg::st_bit;
					endcase
				end
			end
			else if (qtick && !stall)  // see RQ1 see RQ23
			begin
				phase <= phase + 2'd1;
				if (phase == 2'd0 && scl_low && scl_i)
					err_set[`I2CM_ERR_SCLMM] <= 1'b1;  // see RQ13
				if (phase == 2'd2 && !scl_i)
					err_set[`I2CM_ERR_SCLMM] <= 1'b1;  // see RQ13
				case (state)
					i2cm_pkg::st_start:
						case (phase)
							2'd0: sda_low <= 1'b0;
							2'd1: scl_low <= 1'b0;
							2'd2:
							begin
								err_set[`I2CM_ERR_SDAMM] <= !sda_i;  // see RQ13
								sda_low <= 1'b1;
							end
							default:
							begin
								scl_low  <= 1'b1;
								cmd_done <= 1'b1;
								state    <= i2cm_pkg::st_idle;
							end
						endcase
					i2cm_pkg::st_stop:
						case (phase)
							2'd0: sda_low <= 1'b1;
							2'd1: scl_low <= 1'b0;
							2'd2:
							begin
								err_set[`I2CM_ERR_SDAMM] <= sda_i;  // see RQ13
								sda_low <= 1'b0;
							end
							default:
							begin
								cmd_done <= 1'b1;
								state    <= i2cm_pkg::st_idle;
							end
						endcase
					default:
						case (phase)
							2'd0: sda_low <= !bit_out;
							2'd1: scl_low <= 1'b0;
							2'd2:
							begin
								if (drv_sda && sda_i == sda_low)
									err_set[`I2CM_ERR_SDAMM] <= 1'b1;  // see RQ13
								if (!is_tx && bitn != `I2CM_LAST_BIT)
									shreg <= {shreg[6:0], sda_i};  // see RQ4
								if (is_tx && bitn == `I2CM_LAST_BIT && sda_i)
									err_set[`I2CM_ERR_ACK] <= 1'b1;  // see RQ12
							end
							default:
							begin
								scl_low <= 1'b1;
								bitn    <= bitn + 4'd1;
								if (is_tx)
									shreg <= {shreg[6:0], 1'b0};  // see RQ3
								if (bitn == `I2CM_LAST_BIT)
								begin
									cmd_done <= 1'b1;
									rx_done  <= !is_tx;
									state    <= i2cm_pkg::st_idle;
								end
							end
						endcase
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		pins.scl_o  <= !scl_low;
		pins.scl_oe <= resetn && (scl_low || pio[`I2CM_PIO_HDSCL]);
		pins.sda_o  <= !sda_low;
		pins.sda_oe <= resetn && (sda_low || pio[`I2CM_PIO_HDSDA]);
	end

	////////////////////////////////////////////////////////////////////////
	// buffers and dma counter
	always_ff @(posedge clk)
	begin
		if (!resetn)
			transmit_byte <= `I2CM_RST_BYTE;
		else if (wr && wb_adr_i == `I2CM_OFS_TX)
			transmit_byte <= wb_dat_i[7:0];
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			receive_byte <= `I2CM_RST_BYTE;
		else if (rx_done)
			receive_byte <= shreg;  // see RQ2 see RQ4
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			dma_cnt <= 16'h0000;
		else if (wr && wb_adr_i == `I2CM_OFS_DCL)
			dma_cnt[7:0] <= wb_dat_i[7:0];
		else if (wr && wb_adr_i == `I2CM_OFS_DCH)
			dma_cnt[15:8] <= wb_dat_i[7:0];
		else if (cmd_done && (cur_cmd == `I2CM_CMD_RECV ||
			cur_cmd == `I2CM_CMD_XMIT) && dma_mode != 2'h0 &&
			dma_cnt != 16'h0000)  // see RQ9
			dma_cnt <= dma_cnt - 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn || soft_rst)
		begin
			tx_empty <= 1'(`I2CM_DST_RESET >> `I2CM_DST_TXEMPTY);
			rx_upd   <= 1'b0;
		end
		else
		begin
			if (cmd_go && code == `I2CM_CMD_XMIT)
				tx_empty <= 1'b1;
			else if (wr && wb_adr_i == `I2CM_OFS_TX)
				tx_empty <= 1'b0;
			if (rx_done)
				rx_upd <= 1'b1;
			else if (rd && wb_adr_i == `I2CM_OFS_RX)
				rx_upd <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status, errors and interrupt flags; an event wins over a clear
	logic [4:0] err_now;
	logic       start_seen;
	logic       stop_seen;

	assign start_seen = scl_q && scl_i && sda_q && !sda_i;
	assign stop_seen  = scl_q && scl_i && !sda_q && sda_i;
	assign err_now    = err_set |
		{2'b00, 1'b0, stop_seen && state != i2cm_pkg::st_stop,
		start_seen && state != i2cm_pkg::st_start};  // see RQ14 see RQ15

	always_ff @(posedge clk)
	begin
		scl_q <= scl_i;
		sda_q <= sda_i;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn || soft_rst)
			err <= 5'h00;  // see RQ16
		else
			err <= (err_clr ? 5'h00 : err) | err_now;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn || soft_rst)
		begin
			run       <= 1'b0;
			finish    <= 1'b0;
			using_bus <= 1'b0;
			busy      <= 1'b0;
		end
		else
		begin
			if (cmd_done)
			begin
				run    <= 1'b0;  // see RQ22
				finish <= 1'b1;
			end
			else if (cmd_go)
			begin
				run    <= 1'b1;
				finish <= 1'b0;
			end
			if (cmd_done && cur_cmd == `I2CM_CMD_START)
				using_bus <= 1'b1;  // see RQ11
			else if (cmd_done && cur_cmd == `I2CM_CMD_STOP)
				using_bus <= 1'b0;
			if (start_seen)
				busy <= 1'b1;  // see RQ11
			else if (stop_seen)
				busy <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn || soft_rst)
			intcs <= 4'h0;
		else
		begin
			if (wr && wb_adr_i == `I2CM_OFS_INT)
				intcs <= {intcs[3:2] & ~wb_dat_i[3:2], wb_dat_i[1:0]};
			if (|err_now && intcs[`I2CM_INT_EEN])
				intcs[`I2CM_INT_EFLAG] <= 1'b1;  // see RQ17
			if (cmd_done && intcs[`I2CM_INT_CEN])
				intcs[`I2CM_INT_CFLAG] <= 1'b1;  // see RQ18
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			irq_req <= 1'b0;
		else
			irq_req <= intcs[`I2CM_INT_EFLAG] || intcs[`I2CM_INT_CFLAG];
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_busy_cmd_ignored: assert property (  // see RQ6
		run && cmd_wr && !cmd_done |=> $stable(cur_cmd) &&
		$stable(clock_stretch_enable) && $stable(receive_ack_setting))
		else $error("command accepted while running");
	a_ack_one_cycle: assert property (  // see RQ20
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_soft_reset_init: assert property (  // see RQ7
		soft_rst |=> err == 5'h00 && !run && intcs == 4'h0 && tx_empty)
		else $error("soft reset did not initialise");
	a_done_finish: assert property (  // see RQ22
		cmd_done && !soft_rst |=> finish && !run)
		else $error("completion did not set finish");
	a_err_irq_flag: assert property (  // see RQ17
		|err_now && intcs[`I2CM_INT_EEN] && !soft_rst
		|=> intcs[`I2CM_INT_EFLAG] ##1 irq_req)
		else $error("error interrupt flag missing");
	a_comp_irq_flag: assert property (  // see RQ18
		cmd_done && intcs[`I2CM_INT_CEN] && !soft_rst
		|=> intcs[`I2CM_INT_CFLAG])
		else $error("completion interrupt flag missing");
	a_samp_half: assert property (  // see RQ19
		samp_tick && div_m == 4'h0 && $stable(div_m) &&
		!(req && wb_we_i && wb_adr_i == `I2CM_OFS_SDIV)
		|=> !samp_tick ##1 samp_tick)
		else $error("sample divider wrong for ratio zero");
	a_ack_error_set: assert property (  // see RQ12
		err_set[`I2CM_ERR_ACK] && !soft_rst |=> err[`I2CM_ERR_ACK])
		else $error("missing acknowledge not flagged");
	a_unexp_start: assert property (  // see RQ15
		start_seen && state != i2cm_pkg::st_start && !soft_rst
		|=> err[`I2CM_ERR_START])
		else $error("foreign start not flagged");
	a_clear_on_cmd: assert property (  // see RQ16
		err_clr && err_now == 5'h00 && !soft_rst |=> err == 5'h00)
		else $error("valid command did not clear errors");

endmodule : i2cm_top
`default_nettype wire

// ---- tb/i2cm_slave_model.sv ----
`default_nettype none
module i2cm_slave_model (
	input  wire logic       clk,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       ack_en,
	input  wire logic       stretch,
	input  wire logic [7:0] rd_byte,
	output logic            scl_drv,
	output logic            sda_drv,
	output logic      [7:0] got_byte,
	output logic            got_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       scl_q, sda_q, active, first, rd, rdn;
	logic [3:0] cnt, nc;
	logic [7:0] sh;
	logic [5:0] hold;
	// slot that follows the current one; 8 is the acknowledge slot
	assign nc = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
	// direction is taken from the address byte's last bit
	assign rdn = (cnt == 4'h8 && first) ? got_byte[0] : rd;
	assign scl_drv = (hold == 6'h00);
	initial
	begin
		{scl_q, sda_q, active, first, rd, sda_drv} = 6'b110001;
		{cnt, sh, hold, got_byte, got_ack} = '0;
	end
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		scl_q <= scl;
		sda_q <= sda;
		if (hold != 6'h00)
			hold <= hold - 6'h01;
		if (scl && scl_q && sda_q && !sda)
		begin
			active <= 1'b1;
			first <= 1'b1;
			rd <= 1'b0;
			cnt <= 4'hf;
			sda_drv <= 1'b1;
		end
		else if (scl && scl_q && !sda_q && sda)
		begin
			active <= 1'b0;
			sda_drv <= 1'b1;
		end
		else if (active && scl && !scl_q)
		begin
			if (!cnt[3])
				sh <= {sh[6:0], sda};
			else if (cnt == 4'h8)
				got_ack <= sda;
		end
		else if (active && !scl && scl_q)
		begin
			cnt <= nc;
			if (stretch)
				hold <= 6'd40;
			if (nc == 4'h8)
			begin
				got_byte <= sh;
				sda_drv <= (first || !rd) ? !ack_en : 1'b1;
			end
			else
			begin
				rd <= rdn;
				if (cnt == 4'h8)
					first <= 1'b0;
				sda_drv <= rdn ? rd_byte[3'd7 - nc[2:0]] : 1'b1;
			end
		end
	end
endmodule : i2cm_slave_model
`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack, irq_req;
	logic        tb_sda, ack_en, stretch, s_scl, s_sda, got_ack;
	logic [7:0]  wb_adr, rd_val, got_byte;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat, wb_dout;
	int          bad_count = 0;
	int          checks = 0;
	int          cycles = 0;
	i2cm_pkg::i2cm_pins_t pins;
	wire logic   scl_line, sda_line;

	// wired-and with pull-ups
	assign scl_line = (pins.scl_oe ? pins.scl_o : 1'b1) & s_scl;
	assign sda_line = (pins.sda_oe ? pins.sda_o : 1'b1) & s_sda & tb_sda;

	i2cm_top i_i2cm_top (
		.clk      (clk),
		.resetn   (resetn),
		.wb_cyc_i (wb_cyc),
		.wb_stb_i (wb_stb),
		.wb_we_i  (wb_we),
		.wb_adr_i (wb_adr),
		.wb_sel_i (wb_sel),
		.wb_dat_i (wb_dat),
		.wb_dat_o (wb_dout),
		.wb_ack_o (wb_ack),
		.scl_i    (scl_line),
		.sda_i    (sda_line),
		.pins     (pins),
		.irq_req  (irq_req)
	);

	i2cm_slave_model i_i2cm_slave_model (
		.clk      (clk),
		.scl      (scl_line),
		.sda      (sda_line),
		.ack_en   (ack_en),
		.stretch  (stretch),
		.rd_byte  (rd_val),
		.scl_drv  (s_scl),
		.sda_drv  (s_sda),
		.got_byte (got_byte),
		.got_ack  (got_ack)
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task end_of_test;
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			bad_count = bad_count + 1;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= a;
		wb_dat <= d;
		do
			@(posedge clk);
		while (wb_ack !== 1'b1);
		q = wb_dout;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk);
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, {24'h0, d}, q);
	endtask : wr

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(nm, q, e);
	endtask : rchk

	task automatic wait_idle;
		logic [31:0] q;
		do
			wb(1'b0, 8'h0c, 32'h0, q);
		while (q[7] !== 1'b0);
	endtask : wait_idle

	task automatic cmd(input logic [7:0] c);
		wr(8'h08, c);
		wait_idle();
	endtask : cmd

	// start then stop made by another party
	task automatic glitch;
		tb_sda <= 1'b0;
		repeat (4) @(posedge clk);
		tb_sda <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : glitch
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [31:0] e;
		for (int i = 0; i < 14; i++)
		begin
			e = (i == 3) ? 32'h30 : (i == 12) ? 32'h08 : 32'h0;
			rchk("reset value", 8'(i * 4), e);
		end
	endtask : t_reset

	task automatic t_regs;
		logic [31:0] q;
		wb(1'b1, 8'h00, 32'hffff_ff5a, q);
		rchk("transmit byte", 8'h00, 32'h5a);
		wb_sel <= 4'he;
		wr(8'h00, 8'h11);
		wb_sel <= 4'hf;
		rchk("lane masked", 8'h00, 32'h5a);
		wr(8'h04, 8'h77);
		rchk("receive byte", 8'h04, 32'h0);
		wr(8'h34, 8'h55);
		rchk("unmapped", 8'h34, 32'h0);
	endtask : t_regs

	task automatic t_write;
		wr(8'h14, 8'h03);
		wr(8'h08, 8'h01);
		wr(8'h08, 8'h02);
		wait_idle();
		rchk("status after start", 8'h0c, 32'h0d);
		chk("irq on completion", 32'(irq_req), 32'h1);
		rchk("interrupt reg", 8'h14, 32'h07);
		wr(8'h14, 8'h07);
		rchk("interrupt cleared", 8'h14, 32'h03);
		wr(8'h00, 8'ha4);
		cmd(8'h04);
		chk("sent byte", 32'(got_byte), 32'ha4);
		rchk("no ack error", 8'h10, 32'h0);
		ack_en <= 1'b0;
		wr(8'h00, 8'h3c);
		cmd(8'h04);
		chk("sent byte", 32'(got_byte), 32'h3c);
		rchk("ack error", 8'h10, 32'h10);
		rchk("error in status", 8'h0c, 32'h2f);
		rchk("error interrupt", 8'h14, 32'h0f);
		chk("irq on error", 32'(irq_req), 32'h1);
		wr(8'h08, 8'h00);
		rchk("errors cleared", 8'h10, 32'h0);
		ack_en <= 1'b1;
		wr(8'h14, 8'h0c);
		cmd(8'h02);
		rchk("status after stop", 8'h0c, 32'h31);
	endtask : t_write

	task automatic t_read;
		cmd(8'h01);
		wr(8'h00, 8'ha5);
		cmd(8'h04);
		wr(8'h24, 8'h01);
		wr(8'h28, 8'h02);
		for (int i = 0; i < 2; i++)
		begin
			cmd(8'h0b);
			chk("dma ack", 32'(got_ack), 32'(1 - i));
			rchk("dma count", 8'h28, 32'(1 - i));
		end
		wr(8'h24, 8'h00);
		rchk("dma state", 8'h30, 32'h0c);
		for (int i = 0; i < 2; i++)
		begin
			cmd(i == 0 ? 8'h0b : 8'h03);
			rchk("received byte", 8'h04, 32'hc6);
			chk("master ack", 32'(got_ack), 32'(i));
		end
		cmd(8'h02);
	endtask : t_read

	task automatic t_stretch;
		logic [7:0] c;
		for (int i = 0; i < 2; i++)
		begin
			c = (i == 0) ? 8'h10 : 8'h00;
			stretch <= 1'b1;
			cmd(c | 8'h01);
			wr(8'h00, 8'ha4);
			cmd(c | 8'h04);
			rchk("clock mismatch", 8'h10,
				(i == 0) ? 32'h0 : 32'h18);
			stretch <= 1'b0;
			repeat (50) @(posedge clk);
			cmd(c | 8'h02);
		end
	endtask : t_stretch

	task automatic t_foreign;
		glitch();
		rchk("foreign start stop", 8'h10, 32'h03);
		for (int c = 5; c < 7; c++)
		begin
			wr(8'h08, 8'(c));
			rchk("errors kept", 8'h10, 32'h03);
			chk("bus left alone", 32'(pins), 32'h0a);
		end
		wr(8'h08, 8'h07);
		rchk("errors cleared", 8'h10, 32'h0);
	endtask : t_foreign

	task automatic t_soft;
		wr(8'h14, 8'h03);
		wr(8'h08, 8'h18);
		rchk("control bits", 8'h08, 32'h18);
		glitch();
		chk("irq before soft reset", 32'(irq_req), 32'h1);
		wr(8'h08, 8'h38);
		rchk("control after", 8'h08, 32'h0);
		rchk("errors after", 8'h10, 32'h0);
		rchk("interrupt after", 8'h14, 32'h0);
		rchk("status after", 8'h0c, 32'h30);
		rchk("dma state after", 8'h30, 32'h08);
		chk("irq after soft reset", 32'(irq_req), 32'h0);
	endtask : t_soft

	task automatic t_div;
		int         k;
		logic [7:0] m [3] = '{8'h00, 8'h03, 8'h02};
		int         qv [3] = '{2, 12, 16};
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h18, m[i]);
			wr(8'h1c, {7'h0, i == 2});
			wr(8'h08, 8'h01);
			while (pins.sda_oe !== 1'b1)
				@(posedge clk);
			k = 0;
			while (pins.scl_oe !== 1'b1)
			begin
				@(posedge clk);
				k++;
			end
			chk("quarter length", 32'(k), 32'(qv[i]));
			wait_idle();
			cmd(8'h02);
		end
	endtask : t_div
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{resetn, wb_cyc, wb_stb, wb_we, tb_sda, ack_en, stretch} = 7'b0000110;
		wb_adr = 8'h00;
		wb_sel = 4'hf;
		wb_dat = 32'h0;
		rd_val = 8'hc6;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_regs();
		t_write();
		t_read();
		t_stretch();
		t_foreign();
		t_soft();
		t_div();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
